/* File: hw/irq_pwr_ctrl.sv */
// Interrupt enable, four-level priority and idle/power-down control.
// Assumes the CPU core drives the register port and reports handler entry/return.
//
// Overview of operation
// R1 - Global gate blocks all, else per-source enables
// R2 - Enable bits at fixed source positions
// R3 - Software never writes ones to reserved bits
// R4 - Enable register resets to zero
// R5 - Low priority bits per source, reset zero
// R6 - High priority bits pair with low bits
// R7 - Level is high:low, 3 highest
// R8 - Preempt lower only; highest level, fixed poll order
// R9 - Idle gates CPU clock, peripherals keep running
// R10 - Idle holds strobes high, state unchanged
// R11 - Enabled interrupt clears idle bit, serviced
// R12 - Reset of two machine cycles ends idle
// R13 - Power-down stops oscillator, keeps contents
// R14 - Only reset or enabled external pin wakes
// R15 - Wake signal applied after supply restored
// R16 - Low pin restarts oscillator, release completes exit
// R17 - First low restarts, first release completes
// R18 - Resume after instruction that entered power-down
// R19 - Reset exit reinitialises, interrupt exit keeps registers
// R20 - Both bits set behaves as power-down
// R21 - Deep sleep bit enters power-down, reset clears
// R22 - Wake level detected without clock
`timescale 1ns/10ps
`default_nettype none
module irq_pwr_ctrl
	import irq_pwr_pkg::*;
#(
	parameter int SETTLE_CYC = OSC_SETTLE_CYC
)
(
	// Clock, reset and enable.
	input  wire logic       CLK_I,
	input  wire logic       RST_B_I,
	input  wire logic       CE_I,
	// Special register port.
	input  wire logic [7:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	output logic      [7:0] RDATA_O,
	// Interrupt sources, serial at bit 4 down to ext0 at bit 0.
	input  wire logic [4:0] SRC_REQ_I,
	// Active low external wake pins.
	input  wire logic       EXT_WAKE_PIN0_B_I,
	input  wire logic       EXT_WAKE_PIN1_B_I,
	// Handler handshake with the CPU core.
	input  wire logic       IRQ_ACK_I,
	input  wire logic       RETURN_FROM_IRQ_I,
	output logic            IRQ_REQ_O,
	output logic      [2:0] IRQ_ID_O,
	// Power outputs.
	output logic            CPU_CLK_EN_O,
	output logic            OSC_EN_O,
	output logic            STROBE_HOLD_O
);
	// Elaboration check: the settle counter is sixteen bits wide.
	if (SETTLE_CYC < 1 || SETTLE_CYC > 65535)
	begin : gen_bad_settle
		$error("SETTLE_CYC must lie between 1 and 65535");
	end

	// Bus request bundle.
	reg_req_t   req;
	// Software-visible registers.
	logic [7:0] ien_r, ien_nxt;
	logic [4:0] pl_r, pl_nxt;
	logic [4:0] ph_r, ph_nxt;
	logic [7:0] power_ctrl_reg_r, power_ctrl_reg_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	// Stack of active handler levels, one bit per level.
	logic [3:0] act_r, act_nxt;
	logic       req_r, req_nxt;
	logic [2:0] id_r, id_nxt;
	// Power state and settle counter.
	pwr_state_t st_r, st_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic       cpu_en_r, cpu_en_nxt;
	logic       osc_r, osc_nxt;
	logic       hold_r, hold_nxt;
	// Synchronised wake pins.
	logic [1:0] pin_s1_r, pin_s2_r;
	// Enabled pins seen low since the wake began; only these may complete the exit.
	logic [1:0] low_seen_r, low_seen_nxt;
	// Wake pins enabled through both the gate and their own bit.
	logic [1:0] wake_en;
	logic       osc_run;
	// Arbitration results.
	logic [4:0] pend;
	logic [1:0] lvl [NUM_SRC];
	logic [1:0] best_lvl;
	logic [2:0] best_id;
	logic       best_ok;
	logic [1:0] top_act;
	logic       any_act;

	assign req = '{wr: WR_I, rd: RD_I, addr: ADDR_I, wdata: WDATA_I};

	// Level decode per source.
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++)
		begin : gen_lvl
			assign lvl[g] = {ph_r[g], pl_r[g]}; // R6 R7
		end
	endgenerate

	// Gate each request by its own enable and the global gate.
	assign pend = ien_r[GLOBAL_GATE_POS] ? (SRC_REQ_I & ien_r[4:0]) : 5'h00; // R1 R2

	assign wake_en = {ien_r[EXT1_POS], ien_r[EXT0_POS]} & {2{ien_r[GLOBAL_GATE_POS]}}; // R14

	// Clockless wake detection path, armed only in power-down.
	wake_latch u_wake
	(
		.arm_i     (st_r == PWR_DOWN),
		.pin_n_i   ({EXT_WAKE_PIN1_B_I, EXT_WAKE_PIN0_B_I}),
		.en_i      (wake_en),
		.osc_run_o (osc_run)
	);

	// Arbitration: highest level first, then lowest index as the poll order.
	always_comb
	begin
		best_lvl = 2'h0;
		best_id  = 3'h0;
		best_ok  = 1'b0;
		top_act  = 2'h0;
		any_act  = |act_r;
		for (int i = 0; i < 4; i++)
			if (act_r[i])
				top_act = 2'(i);
		for (int i = NUM_SRC - 1; i >= 0; i--)
			if (pend[i] && (!best_ok || lvl[i] >= best_lvl))
			begin
				best_ok  = 1'b1; // R8
				best_lvl = lvl[i];
				best_id  = 3'(i);
			end
		if (best_ok && any_act && best_lvl <= top_act)
			best_ok = 1'b0; // R8
	end

	// Register file, handler tracking and power sequencing.
	always_comb
	begin
		ien_nxt    = ien_r;
		pl_nxt     = pl_r;
		ph_nxt     = ph_r;
		power_ctrl_reg_nxt   = power_ctrl_reg_r;
		rdata_nxt  = rdata_r;
		act_nxt    = act_r;
		req_nxt    = req_r;
		id_nxt     = id_r;
		st_nxt     = st_r;
		cnt_nxt    = cnt_r;
		low_seen_nxt = low_seen_r;
		// Writes; reserved bits of the enable and power registers are stored as written and software keeps them zero.
		if (req.wr)
		begin
			case (req.addr)
				IRQ_ENABLE_OFS:    ien_nxt  = req.wdata; // R3 R4
				IRQ_PRIO_LOW_OFS:  pl_nxt   = req.wdata[4:0]; // R5
				IRQ_PRIO_HIGH_OFS: ph_nxt   = req.wdata[4:0]; // R6
				POWER_CTRL_OFS:    power_ctrl_reg_nxt = req.wdata; // R21
				default:           ;
			endcase
		end
		// Reads answer in the next cycle; unmapped reads return zero.
		if (req.rd)
		begin
			case (req.addr)
				IRQ_ENABLE_OFS:    rdata_nxt = ien_r;
				IRQ_PRIO_LOW_OFS:  rdata_nxt = {3'h0, pl_r};
				IRQ_PRIO_HIGH_OFS: rdata_nxt = {3'h0, ph_r};
				POWER_CTRL_OFS:    rdata_nxt = power_ctrl_reg_r;
				default:           rdata_nxt = 8'h00;
			endcase
		end
		// Request a handler until the core takes it.
		req_nxt = best_ok;
		if (best_ok)
			id_nxt = best_id;
		if (IRQ_ACK_I && req_r)
		begin
			act_nxt[lvl[id_r]] = 1'b1;
			req_nxt = 1'b0;
		end
		// A return retires the highest active level.
		if (RETURN_FROM_IRQ_I)
		begin
			for (int i = 0; i < 4; i++)
				if (act_r[i] && 2'(i) == top_act)
					act_nxt[i] = 1'b0;
		end
		// Power mode sequencing.
		case (st_r)
			PWR_RUN:
			begin
				if (power_ctrl_reg_r[DEEP_SLEEP_POS])
					st_nxt = PWR_DOWN; // R13 R20 R21
				else if (power_ctrl_reg_r[CPU_SLEEP_POS])
					st_nxt = PWR_IDLE; // R9
			end
			PWR_IDLE:
			begin
				if (best_ok)
				begin
					power_ctrl_reg_nxt[CPU_SLEEP_POS] = 1'b0; // R11
					st_nxt = PWR_RUN;
				end
			end
			PWR_DOWN:
			begin
				cnt_nxt = 16'h0000;
				low_seen_nxt = 2'h0;
				if (osc_run)
					st_nxt = PWR_WAKE; // R14 R16
			end
			PWR_WAKE:
			begin
				if (cnt_r < 16'(SETTLE_CYC))
					cnt_nxt = cnt_r + 16'h0001;
				// Remember every enabled pin seen low, so a release during settling is not lost.
				low_seen_nxt = low_seen_r | (~pin_s2_r & wake_en); // R16
				// First released pin after settling completes the exit.
				if (cnt_r >= 16'(SETTLE_CYC) && |(pin_s2_r & low_seen_r))
				begin
					power_ctrl_reg_nxt[DEEP_SLEEP_POS] = 1'b0; // R17 R18 R20
					power_ctrl_reg_nxt[CPU_SLEEP_POS]  = 1'b0; // R20
					st_nxt = PWR_RUN;
				end
			end
			default: st_nxt = PWR_RUN;
		endcase
	end

	// Output next values, all registered.
	always_comb
	begin
		cpu_en_nxt = (st_nxt == PWR_RUN); // R9 R10
		osc_nxt    = (st_nxt != PWR_DOWN); // R13
		hold_nxt   = (st_nxt == PWR_IDLE); // R10
	end

	// Registers; the reset exit reinitialises every special register.
	always_ff @(posedge CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			ien_r      <= IRQ_ENABLE_RST; // R4 R19
			pl_r       <= PRIO_RST; // R5
			ph_r       <= PRIO_RST; // R6
			power_ctrl_reg_r     <= POWER_CTRL_RST; // R21 R12
			rdata_r    <= 8'h00;
			act_r      <= 4'h0;
			req_r      <= 1'b0;
			id_r       <= 3'h0;
			st_r       <= PWR_RUN;
			cnt_r      <= 16'h0000;
			cpu_en_r   <= 1'b1;
			osc_r      <= 1'b1;
			hold_r     <= 1'b0;
			pin_s1_r   <= 2'h3;
			pin_s2_r   <= 2'h3;
			low_seen_r <= 2'h0;
		end
		else if (CE_I)
		begin
			ien_r      <= ien_nxt;
			pl_r       <= pl_nxt;
			ph_r       <= ph_nxt;
			power_ctrl_reg_r     <= power_ctrl_reg_nxt;
			rdata_r    <= rdata_nxt;
			act_r      <= act_nxt;
			req_r      <= req_nxt;
			id_r       <= id_nxt;
			st_r       <= st_nxt;
			cnt_r      <= cnt_nxt;
			cpu_en_r   <= cpu_en_nxt;
			osc_r      <= osc_nxt;
			hold_r     <= hold_nxt;
			pin_s1_r   <= {EXT_WAKE_PIN1_B_I, EXT_WAKE_PIN0_B_I};
			pin_s2_r   <= pin_s1_r;
			low_seen_r <= low_seen_nxt;
		end
	end

	assign RDATA_O       = rdata_r;
	assign IRQ_REQ_O     = req_r;
	assign IRQ_ID_O      = id_r;
	assign CPU_CLK_EN_O  = cpu_en_r;
	assign OSC_EN_O      = osc_r;
	assign STROBE_HOLD_O = hold_r;

	// Gate closed means no request is raised.
	property p_gate;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(CE_I && !ien_r[GLOBAL_GATE_POS]) |=> !req_r;
	endproperty
	a_gate: assert property (p_gate) else $error("request with gate closed"); // R1

	// A raised request names an enabled source.
	property p_enabled;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(CE_I && best_ok) |-> (ien_r[GLOBAL_GATE_POS] && ien_r[best_id] && SRC_REQ_I[best_id]);
	endproperty
	a_enabled: assert property (p_enabled) else $error("disabled source requested"); // R2

	// The low priority register reads back with zero upper bits.
	property p_prio_read;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(CE_I && req.rd && req.addr == IRQ_PRIO_LOW_OFS) |=> rdata_r == {3'h0, $past(pl_r)};
	endproperty
	a_prio_read: assert property (p_prio_read) else $error("low priority read wrong"); // R5

	// No request at or below the running level.
	property p_preempt;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(CE_I && req_r && any_act) |-> lvl[id_r] > top_act;
	endproperty
	a_preempt: assert property (p_preempt) else $error("preempted equal level"); // R8

	// Idle holds the CPU clock off and strobes high.
	property p_idle;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(CE_I && st_r == PWR_RUN && !power_ctrl_reg_r[DEEP_SLEEP_POS] && power_ctrl_reg_r[CPU_SLEEP_POS])
		|=> (!cpu_en_r && hold_r);
	endproperty
	a_idle: assert property (p_idle) else $error("idle entry wrong"); // R9 R10

	// Idle ends when an enabled request appears.
	property p_idle_exit;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(CE_I && st_r == PWR_IDLE && best_ok) |=> (!power_ctrl_reg_r[CPU_SLEEP_POS] && cpu_en_r);
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle not left"); // R11

	// Power-down stops the oscillator.
	property p_down;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(CE_I && st_r == PWR_RUN && power_ctrl_reg_r[DEEP_SLEEP_POS]) |=> !osc_r;
	endproperty
	a_down: assert property (p_down) else $error("oscillator not stopped"); // R13 R20

	// Without an enabled low pin the device stays down.
	property p_stay_down;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(CE_I && st_r == PWR_DOWN && !osc_run) |=> st_r == PWR_DOWN;
	endproperty
	a_stay_down: assert property (p_stay_down) else $error("spurious wake"); // R14 R22

	// Exit clears both power bits.
	property p_exit_bits;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(CE_I && st_r == PWR_WAKE && st_nxt == PWR_RUN) |=> power_ctrl_reg_r[1:0] == 2'h0;
	endproperty
	a_exit_bits: assert property (p_exit_bits) else $error("power bits not cleared"); // R16 R17 R18
endmodule
`default_nettype wire

/* File: hw/irq_pwr_pkg.sv */
// Package for the interrupt enable, priority and power mode block.
// Assumes a byte-wide special register port with one-cycle read latency.
package irq_pwr_pkg;
	// Special register offsets.
	localparam logic [7:0] IRQ_ENABLE_OFS    = 8'ha8;
	localparam logic [7:0] IRQ_PRIO_HIGH_OFS = 8'hb7;
	localparam logic [7:0] IRQ_PRIO_LOW_OFS  = 8'hb8;
	localparam logic [7:0] POWER_CTRL_OFS    = 8'h87;
	// Field positions.
	localparam int GLOBAL_GATE_POS  = 7;
	localparam int SERIAL_POS       = 4;
	localparam int TIMER1_POS       = 3;
	localparam int EXT1_POS         = 2;
	localparam int TIMER0_POS       = 1;
	localparam int EXT0_POS         = 0;
	localparam int CPU_SLEEP_POS    = 0;
	localparam int DEEP_SLEEP_POS   = 1;
	localparam int USER_FLAG0_POS   = 2;
	localparam int USER_FLAG1_POS   = 3;
	localparam int NUM_SRC          = 5;
	// Reset values.
	localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
	localparam logic [4:0] PRIO_RST       = 5'h00;
	localparam logic [7:0] POWER_CTRL_RST = 8'h00;
	// Oscillator settle time after a wake, in ns, and its cycle count.
	localparam int CLK_PERIOD_NS  = 10;
	localparam int OSC_SETTLE_NS  = 1000;
	localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Register access request carried as one group.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	// Power state, one-hot.
	typedef enum logic [3:0] {
		PWR_RUN   = 4'b0001,
		PWR_IDLE  = 4'b0010,
		PWR_DOWN  = 4'b0100,
		PWR_WAKE  = 4'b1000
	} pwr_state_t;
endpackage

/* File: hw/wake_latch.sv */
// Clockless wake detector for the stopped oscillator.
// Assumes the wake pins are active low and the arm level is stable while stopped.
`timescale 1ns/10ps
`default_nettype none
module wake_latch
(
	// Arm and pins.
	input  wire logic       arm_i,
	input  wire logic [1:0] pin_n_i,
	input  wire logic [1:0] en_i,
	// Detection.
	output logic            osc_run_o
);
	// Pure gates: no clock runs in power-down, so the low level itself releases the oscillator.
	assign osc_run_o = ~arm_i | (|(en_i & ~pin_n_i)); // R22
endmodule
`default_nettype wire

/* File: tb/irq_cpu_model.sv */
// Model of the CPU core handshake and of the two wake pins.
// Assumes one clock shared with the block and an active low reset.
`timescale 1ns/10ps
`default_nettype none
module irq_cpu_model
(
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// Commands from the bench.
	input  wire logic       ack_en_i,
	input  wire logic       ret_go_i,
	input  wire logic [1:0] pin_low_i,
	// Block side.
	input  wire logic       irq_req_i,
	output logic            irq_ack_o,
	output logic            ret_o,
	output logic      [1:0] pin_n_o
);
	logic [2:0] hold_r; // Hold-off, so one request is never taken twice.
	// A pin not pulled low floats to its pull-up level.
	assign pin_n_o = ~pin_low_i;
	// Take a request only while allowed; return when told.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			irq_ack_o <= 1'b0;
			ret_o     <= 1'b0;
			hold_r    <= 3'h0;
		end
		else
		begin
			irq_ack_o <= ack_en_i && irq_req_i && hold_r == 3'h0;
			ret_o     <= ret_go_i;
			if (ack_en_i && irq_req_i && hold_r == 3'h0)
				hold_r <= 3'h7;
			else if (hold_r != 3'h0)
				hold_r <= hold_r - 3'h1;
		end
	end
endmodule
`default_nettype wire

/* File: tb/irq_enable_priority_power_modes_tb.sv */
// Bench for the interrupt and power control block.
// Assumes the register port of the block and the core model beside it.
`timescale 1ns/10ps
`default_nettype none
module irq_enable_priority_power_modes_tb;
	import irq_pwr_pkg::*;
	logic       clk, rst_b, wr, rd, ack_en, ret_go, ack, ret;
	logic [7:0] addr, wdata, rdata;
	logic [4:0] src;
	logic [1:0] pin_low, pin_n;
	logic       req, cpu_en, osc_en, hold;
	logic [2:0] id;
	int         n_fail, compares;
	logic [1:0] lv, m;
	// Free running 100 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	irq_pwr_ctrl #(.SETTLE_CYC(2)) u_dut (.CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.SRC_REQ_I(src), .EXT_WAKE_PIN0_B_I(pin_n[0]), .EXT_WAKE_PIN1_B_I(pin_n[1]),
		.IRQ_ACK_I(ack), .RETURN_FROM_IRQ_I(ret), .IRQ_REQ_O(req), .IRQ_ID_O(id),
		.CPU_CLK_EN_O(cpu_en), .OSC_EN_O(osc_en), .STROBE_HOLD_O(hold));
	irq_cpu_model u_cpu (.clk_i(clk), .rst_b_i(rst_b), .ack_en_i(ack_en),
		.ret_go_i(ret_go), .pin_low_i(pin_low), .irq_req_i(req), .irq_ack_o(ack),
		.ret_o(ret), .pin_n_o(pin_n));
	// Compare and count.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle write strobe.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read strobe; data is looked at in the following cycle only.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// Let n edges pass, then sample settled outputs.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Change the source requests or wake pins at an edge.
	task automatic set_src(input logic [4:0] s);
		@(posedge clk) src <= s;
	endtask
	task automatic set_pin(input logic [1:0] p);
		@(posedge clk) pin_low <= p;
	endtask
	// The one closing point of the run.
	task automatic stop_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Watchdog: the whole sequence needs well under 2000 cycles.
	initial
	begin
		repeat (5000) @(posedge clk);
		n_fail++;
		stop_test;
	end
	initial
	begin
		{rst_b, wr, rd, ack_en, ret_go, addr, wdata, src, pin_low} = '0;
		n_fail = 0;
		compares = 0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk(IRQ_ENABLE_OFS, 8'h00);
		rd_chk(IRQ_PRIO_LOW_OFS, 8'h00);
		rd_chk(IRQ_PRIO_HIGH_OFS, 8'h00);
		rd_chk(POWER_CTRL_OFS, 8'h00);
		rd_chk(8'h55, 8'h00);
		// Enables without the gate pass nothing; reserved bits stay zero.
		wr_reg(IRQ_ENABLE_OFS, 8'h1f);
		set_src(5'h1f);
		cyc(3);
		chk({7'h0, req}, 8'h00);
		wr_reg(IRQ_ENABLE_OFS, 8'h9f);
		cyc(3);
		chk({7'h0, req}, 8'h01);
		chk({5'h0, id}, 8'h00);
		rd_chk(IRQ_ENABLE_OFS, 8'h9f);
		// One enable at a time picks out its own source.
		for (int i = 0; i < NUM_SRC; i++)
		begin
			wr_reg(IRQ_ENABLE_OFS, 8'h80 | (8'h01 << i));
			cyc(3);
			chk({5'h0, id}, 8'(i));
		end
		// Serial one level above ext0, for every level pair.
		wr_reg(IRQ_ENABLE_OFS, 8'h9f);
		for (int l = 1; l < 4; l++)
		begin
			lv = 2'(l);
			m  = 2'(l - 1);
			wr_reg(IRQ_PRIO_HIGH_OFS, {3'h0, lv[1], 3'h0, m[1]});
			wr_reg(IRQ_PRIO_LOW_OFS, {3'h0, lv[0], 3'h0, m[0]});
			cyc(3);
			chk({5'h0, id}, 8'h04);
		end
		rd_chk(IRQ_PRIO_HIGH_OFS, 8'h11);
		rd_chk(IRQ_PRIO_LOW_OFS, 8'h10);
		// Ext0 at level 2 is taken; level 0 may not preempt, level 3 may.
		set_src(5'h01);
		@(posedge clk) ack_en <= 1'b1;
		cyc(3);
		@(posedge clk) ack_en <= 1'b0;
		set_src(5'h02);
		cyc(3);
		chk({7'h0, req}, 8'h00);
		set_src(5'h12);
		cyc(3);
		chk({4'h0, req, id}, 8'h0c);
		@(posedge clk) ret_go <= 1'b1;
		@(posedge clk) ret_go <= 1'b0;
		set_src(5'h00);
		// Idle: only an enabled request ends it; the user flag survives.
		wr_reg(IRQ_ENABLE_OFS, 8'h81);
		wr_reg(POWER_CTRL_OFS, 8'h09);
		cyc(3);
		chk({5'h0, cpu_en, hold, osc_en}, 8'h03);
		set_src(5'h02);
		cyc(3);
		chk({7'h0, cpu_en}, 8'h00);
		set_src(5'h01);
		cyc(4);
		chk({7'h0, cpu_en}, 8'h01);
		set_src(5'h00);
		rd_chk(POWER_CTRL_OFS, 8'h08);
		// Both bits: behaves as power-down; a disabled pin cannot wake.
		wr_reg(POWER_CTRL_OFS, 8'h03);
		cyc(3);
		chk({7'h0, osc_en}, 8'h00);
		set_pin(2'b10);
		cyc(4);
		chk({7'h0, osc_en}, 8'h00);
		set_pin(2'b11);
		cyc(3);
		chk({7'h0, osc_en}, 8'h01);
		set_pin(2'b10);
		cyc(8);
		set_pin(2'b00);
		rd_chk(POWER_CTRL_OFS, 8'h00);
		rd_chk(IRQ_ENABLE_OFS, 8'h81);
		// Both pins enabled: first low restarts, first release completes.
		wr_reg(IRQ_ENABLE_OFS, 8'h85);
		wr_reg(POWER_CTRL_OFS, 8'h02);
		cyc(3);
		set_pin(2'b10);
		cyc(3);
		chk({7'h0, osc_en}, 8'h01);
		set_pin(2'b11);
		cyc(3);
		rd_chk(POWER_CTRL_OFS, 8'h02);
		set_pin(2'b01);
		cyc(8);
		rd_chk(POWER_CTRL_OFS, 8'h00);
		set_pin(2'b00);
		// Reset leaves power-down and reloads the power, low priority and enable registers.
		wr_reg(IRQ_PRIO_LOW_OFS, 8'h1f);
		wr_reg(POWER_CTRL_OFS, 8'h02);
		cyc(3);
		@(posedge clk) rst_b <= 1'b0;
		repeat (24) @(posedge clk);
		rst_b <= 1'b1;
		cyc(2);
		chk({7'h0, osc_en}, 8'h01);
		rd_chk(POWER_CTRL_OFS, 8'h00);
		rd_chk(IRQ_PRIO_LOW_OFS, 8'h00);
		rd_chk(IRQ_ENABLE_OFS, 8'h00);
		stop_test;
	end
endmodule
`default_nettype wire
